// ===== bench/uar_assertions.sv
/*
 checker on uar_top ports: filter outputs, interrupt cause, bus answers.
 assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_chk (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                rx_valid,
	input wire uar_pkg::uar_frame_s rx_frame,
	input wire logic                frame_accept_q,
	input wire logic [7:0]          frame_data_q,
	input wire logic                irq_q,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_acc_cause; frame_accept_q |-> $past(rx_valid); endproperty
	a_acc_cause: assert property (p_acc_cause) else $error("accept without frame");
	property p_acc_data; frame_accept_q |-> frame_data_q == $past(rx_frame.data); endproperty
	a_acc_data: assert property (p_acc_data) else $error("accepted data wrong");
	property p_irq_rise; $rose(irq_q) |-> $past(frame_accept_q) || $past(s_axi_bvalid); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	property p_irq_fall; $fell(irq_q) |-> $past(s_axi_bvalid); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
	property p_wr_ans; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
	property p_rd_ans; s_rd_take |-> ##[1:3] s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
	property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
	property p_rd_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
endmodule // uar_chk
bind uar_top uar_chk i_uar_chk (
	.aclk, .aresetn, .rx_valid, .rx_frame, .frame_accept_q, .frame_data_q, .irq_q,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);
`default_nettype wire

// ===== bench/uar_node.sv
/*
 far node model: puts one frame per call on the receive strobe.
 assumes the caller enters send just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_node (
	input  wire logic          aclk,
	output logic                rx_valid,
	output uar_pkg::uar_frame_s rx_frame
);
	initial rx_valid = 1'b0;
	initial rx_frame = '0;
	task automatic send(input logic [7:0] d, input logic n, input logic s);
		rx_valid <= 1'b1;
		rx_frame <= {d, n, s};
		@(posedge aclk);
		rx_valid <= 1'b0;
		// inverse after the frame so a stale value can never pass for data
		rx_frame <= {~d, ~n, ~s};
	endtask
endmodule // uar_node
`default_nettype wire

// ===== bench/uar_top_tb.sv
/*
 testbench for uar_top: registers over axi4-lite, filtered frames, interrupt.
 assumes uar_node drives the receive side and the checker is bound.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_top_tb;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  frame_data_q;
	logic frame_accept_q, irq_q, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, rx_valid;
	uar_pkg::uar_frame_s rx_frame;
	int fail_count = 0, checked = 0, cyc = 0;
	logic [7:0]  exp_q[$];
	logic [31:0] rng = 32'h5049;
	uar_top i_uar_top (
		.aclk, .aresetn, .rx_valid, .rx_frame, .frame_accept_q, .frame_data_q, .irq_q,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);
	uar_node i_uar_node (.aclk, .rx_valid, .rx_frame);
	initial forever #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic hit(input logic [7:0] d, input logic [7:0] o, input logic [7:0] m);
		return (((d ^ o) & m) == 8'h00) || (((d ^ (o | m)) & (o | m)) == 8'h00);
	endfunction
	task automatic wr(input logic [31:0] a, d, input logic [1:0] e = uar_pkg::resp_okay);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, e);
	endtask
	task automatic rd(input logic [31:0] a, x, input logic [1:0] e = uar_pkg::resp_okay);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, x);
		chk(s_axi_rresp, e);
	endtask
	always @(posedge aclk) begin
		if (frame_accept_q === 1'b1) chk(frame_data_q, exp_q.size() ? exp_q.pop_front() : 'x);
		if (++cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		logic [7:0] d, o, m;
		int md;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd(4 * i, 0);
		rd(32'h10, 0, uar_pkg::resp_slverr);
		wr(32'h10, 1, uar_pkg::resp_slverr);
		$display("test reset done");
		for (int k = 0; k < 5; k++) begin
			o = k[0] ? 8'hf1 : 8'h56;
			m = (k == 3) ? 8'hff : (k[0] ? 8'hfa : 8'hfc);
			md = (k == 4) ? 2 : k;
			wr(uar_pkg::addr_off, o);
			wr(uar_pkg::mask_off, m);
			wr(uar_pkg::ctrl_off, 32'(md) | (32'(k != 4) << uar_pkg::mpe_bit));
			for (int j = 0; j < 12; j++) begin
				rng = xs(rng);
				d = rng[4] ? o ^ (rng[15:8] & ~m) : rng[15:8];
				// mode 1 qualifies by stop bit, nine-bit modes by ninth bit
				if (k == 4 || md == 0 || ((md == 1 ? rng[1] : rng[0]) && hit(d, o, m))) begin
					exp_q.push_back(d);
				end
				@(posedge aclk);
				i_uar_node.send(d, rng[0], rng[1]);
			end
			repeat (3) @(posedge aclk);
			chk(exp_q.size(), 0);
			$display("test config %0d done", k);
		end
		wr(uar_pkg::stat_off, 32'h103);
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back(8'h5a);
			@(posedge aclk);
			i_uar_node.send(8'h5a, 1'b0, 1'b0);
			repeat (3) @(posedge aclk);
			chk(irq_q, i == 0);
			wr(uar_pkg::stat_off, 32'h003);
			repeat (3) @(posedge aclk);
			chk(irq_q, 0);
		end
		rd(uar_pkg::stat_off, 32'h000);
		$display("test irq done");
		finish_test();
	end
endmodule // uar_top_tb
`default_nettype wire

// ===== rtl/uar_match.sv
/*
 address comparator: given and broadcast match of one received byte.
 assumes own address and mask are stable registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_match #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] rx_byte,
	input  wire logic [W-1:0] own_addr,
	input  wire logic [W-1:0] mask,
	output logic              hit
);
	logic [W-1:0] given_ok;
	logic [W-1:0] bcast_ok;
	logic [W-1:0] bcast;

	assign bcast = own_addr | mask;

	for (genvar i = 0; i < W; i++) begin : g_bit
		assign given_ok[i] = ~mask[i] | (rx_byte[i] == own_addr[i]);
		assign bcast_ok[i] = ~bcast[i] | rx_byte[i];
	end

	// a mask of all ones turns the given address into the exact address
	assign hit = (&given_ok) | (&bcast_ok);
endmodule // uar_match
`default_nettype wire

// ===== rtl/uar_pkg.sv
/*
 address recognition package: register map, field positions, reset values, carriers.
 assumes an axi4-lite master on the same clock; registers are word aligned.
*/
package uar_pkg;
	localparam logic [3:0] ctrl_off   = 4'h0;
	localparam logic [3:0] addr_off   = 4'h4;
	localparam logic [3:0] mask_off   = 4'h8;
	localparam logic [3:0] stat_off   = 4'hc;
	localparam int         mode_lsb   = 0;
	localparam int         mpe_bit    = 2;
	localparam int         done_bit   = 0;
	localparam int         ovr_bit    = 1;
	localparam logic [7:0] addr_rst   = 8'h00;
	localparam logic [7:0] mask_rst   = 8'h00;
	localparam logic [2:0] ctrl_rst   = 3'h0;
	localparam logic [1:0] resp_okay  = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef enum logic [1:0] {uar_mode0, uar_mode1, uar_mode2, uar_mode3} uar_mode_e;

	typedef struct packed {
		logic [7:0] data;
		logic       ninth;
		logic       stop_ok;
	} uar_frame_s;
endpackage

// ===== rtl/uar_top.sv
/*
 receive-side address filter with axi4-lite registers and a level interrupt.
 assumes the serial receiver delivers one frame per valid pulse on aclk.
*/
`timescale 1ns/10ps
`default_nettype none
module uar_top (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              rx_valid,
	input  wire uar_pkg::uar_frame_s rx_frame,
	output logic                   frame_accept_q,
	output logic [7:0]             frame_data_q,
	output logic                   irq_q,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	logic [2:0]  serial_control_reg_q;
	logic [7:0]  own_address_reg_q;
	logic [7:0]  address_mask_reg_q;
	logic [1:0]  status_q;
	logic [1:0]  irq_mask_q;
	logic [31:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic        hit;
	logic        filter_on;
	logic        mode_zero;
	logic        addr_frame;
	logic        deliver;
	logic        wr_fire;
	logic [1:0]  clr_mask;
	logic [3:0]  wr_off;
	logic [3:0]  rd_off;
	logic        wr_bad;
	uar_pkg::uar_mode_e mode;

	assign mode = uar_pkg::uar_mode_e'(serial_control_reg_q[uar_pkg::mode_lsb +: 2]);
	assign mode_zero = (mode == uar_pkg::uar_mode0);
	// enable bit is simply disregarded in mode 0 rather than cleared
	assign filter_on = serial_control_reg_q[uar_pkg::mpe_bit] & ~mode_zero;
	// mode 1 has no ninth bit; the stop bit stands in for it
	assign addr_frame = (mode == uar_pkg::uar_mode1) ? rx_frame.stop_ok
	                                                  : rx_frame.ninth;

	uar_match #(
		.W(8)
	) u_match (
		.rx_byte  (rx_frame.data),
		.own_addr (own_address_reg_q),
		.mask     (address_mask_reg_q),
		.hit      (hit)
	);

	// data frames pass freely when filtering is off; addresses must match and qualify
	assign deliver = rx_valid & (~filter_on | (addr_frame & hit));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_accept_q <= 1'b0;
			frame_data_q   <= 8'h00;
		end else begin
			frame_accept_q <= deliver;
			if (deliver) begin
				frame_data_q <= rx_frame.data;
			end
		end
	end

	assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign wr_off  = aw_addr_q[3:0];
	assign rd_off  = s_axi_araddr[3:0];
	assign wr_bad  = (aw_addr_q[31:4] != 28'h0000000) || (wr_off[1:0] != 2'h0);
	assign clr_mask = (wr_fire && !wr_bad && wr_off == uar_pkg::stat_off && w_strb_q[0])
	                  ? w_data_q[1:0] : 2'h0;

	// sticky events: set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= 2'h0;
		end else begin
			status_q[uar_pkg::done_bit] <= deliver | (status_q[uar_pkg::done_bit]
			                               & ~clr_mask[uar_pkg::done_bit]);
			status_q[uar_pkg::ovr_bit]  <= (deliver & status_q[uar_pkg::done_bit])
			                               | (status_q[uar_pkg::ovr_bit] & ~clr_mask[uar_pkg::ovr_bit]);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & irq_mask_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 32'h00000000;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= uar_pkg::resp_okay;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_bad ? uar_pkg::resp_slverr : uar_pkg::resp_okay;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_control_reg_q <= uar_pkg::ctrl_rst;
			own_address_reg_q    <= uar_pkg::addr_rst;
			address_mask_reg_q   <= uar_pkg::mask_rst;
			irq_mask_q           <= 2'h0;
		end else if (wr_fire && !wr_bad && w_strb_q[0]) begin
			case (wr_off)
				uar_pkg::ctrl_off: begin
					serial_control_reg_q <= w_data_q[2:0];
				end
				uar_pkg::addr_off: begin
					own_address_reg_q <= w_data_q[7:0];
				end
				uar_pkg::mask_off: begin
					address_mask_reg_q <= w_data_q[7:0];
				end
				uar_pkg::stat_off: begin
					irq_mask_q <= w_data_q[9:8];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= uar_pkg::resp_okay;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= uar_pkg::resp_okay;
				if (s_axi_araddr[31:4] != 28'h0000000 || rd_off[1:0] != 2'h0) begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= uar_pkg::resp_slverr;
				end else begin
					case (rd_off)
						uar_pkg::ctrl_off: s_axi_rdata <= {29'h0, serial_control_reg_q};
						uar_pkg::addr_off: s_axi_rdata <= {24'h0, own_address_reg_q};
						uar_pkg::mask_off: s_axi_rdata <= {24'h0, address_mask_reg_q};
						uar_pkg::stat_off: s_axi_rdata <= {22'h0, irq_mask_q, 6'h0, status_q};
						default:           s_axi_rdata <= 32'h00000000;
					endcase
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // uar_top
`default_nettype wire
